// ---- pss_pkg.sv ----
// Package of offsets, field positions, reset values and carrier types for the status summary.
package pss_pkg;

    // ************************************************************
    // Register map (byte addresses on the AHB-Lite slave)
    // ************************************************************
    localparam logic [7:0] PSS_OFF_SUMMARY = 8'h00;  // Read-only status summary.
    localparam logic [7:0] PSS_OFF_CTRL = 8'h04;     // Crossover and signal-detect control.
    localparam logic [7:0] PSS_OFF_IRQ_STAT = 8'h08; // Sticky event status, read-only.
    localparam logic [7:0] PSS_OFF_IRQ_CLR = 8'h0c;  // Write one to clear, write-only.
    localparam logic [7:0] PSS_OFF_IRQ_EN = 8'h10;   // Event enable, same layout.

    // ************************************************************
    // Status summary field positions
    // ************************************************************
    localparam int unsigned PSS_B_RSVD = 15;   // Reserved, reads zero.
    localparam int unsigned PSS_B_XOVER = 14;  // Crossover state.
    localparam int unsigned PSS_B_RXERR = 13;  // Receive error latch.
    localparam int unsigned PSS_B_POL = 12;    // Polarity copy.
    localparam int unsigned PSS_B_FCS = 11;    // False carrier latch.
    localparam int unsigned PSS_B_SD = 10;     // Qualified signal detect.
    localparam int unsigned PSS_B_LOCK = 9;    // Descrambler lock.
    localparam int unsigned PSS_B_PAGE = 8;    // Page received.
    localparam int unsigned PSS_B_INT = 7;     // Interrupt pending.

    // ************************************************************
    // Control register fields and reset values
    // ************************************************************
    localparam int unsigned PSS_CTRL_W = 3;           // Control register width.
    localparam int unsigned PSS_C_XEN = 0;            // auto_crossover_enable.
    localparam int unsigned PSS_C_XFORCE = 1;         // crossover_force.
    localparam int unsigned PSS_C_SDQUAL = 2;         // Qualify signal detect with lock.
    localparam logic [2:0] PSS_CTRL_RST = 3'h0;       // Control reset value.
    localparam logic [15:0] PSS_SUMMARY_RST = 16'h0000; // Summary reset value.

    // ************************************************************
    // Interrupt event positions
    // ************************************************************
    localparam int unsigned PSS_NEV = 6;          // Number of interrupt events.
    localparam int unsigned PSS_E_RXERR = 0;      // Receive error latch rose.
    localparam int unsigned PSS_E_FCS = 1;        // False carrier latch rose.
    localparam int unsigned PSS_E_PAGE = 2;       // Page received rose.
    localparam int unsigned PSS_E_INT = 3;        // Interrupt pending rose.
    localparam int unsigned PSS_E_SDLOSS = 4;     // Signal detect latched low.
    localparam int unsigned PSS_E_LOCKLOSS = 5;   // Descrambler lock latched low.
    localparam logic [5:0] PSS_IRQ_RST = 6'h00;   // Status and enable reset value.

    // ************************************************************
    // Carrier types
    // ************************************************************
    // Live conditions and event pulses from the rest of the PHY.
    typedef struct packed {
        logic xover_live;     // Crossover algorithm is currently in crossed state.
        logic rx_error;       // Receive error event pulse.
        logic false_carrier;  // False carrier event pulse.
        logic polarity_inv;   // Inverted receive polarity detected (level).
        logic raw_sd;         // Raw signal detect from the media side (level).
        logic descr_lock;     // Descrambler lock (level).
        logic page_rcvd;      // New link code word page received pulse.
        logic int_evt;        // Internal interrupt raised pulse.
    } pss_phy_t;

    // One-cycle pulses marking reads of neighbouring registers.
    typedef struct packed {
        logic rd_rx_err_count;  // Read of receive_error_count_reg.
        logic rd_fc_count;      // Read of false_carrier_count_reg.
        logic rd_tenbase;       // Read of tenbase_status_control_reg.
        logic rd_an_exp;        // Read of autoneg_expansion_reg.
        logic rd_int_status;    // Read of interrupt_status_event_reg.
    } pss_rdclr_t;

endpackage : pss_pkg

// ---- pss_flag_hi.sv ----
// Latched-high flag: set by an event, cleared by a read strobe, set wins.
`timescale 1ns/1ps

module pss_flag_hi (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Set and clear strobes.
    input wire logic set,
    input wire logic clr,
    // Flag value.
    output logic q
);

    logic q_reg;   // Flag storage.
    logic q_next;  // Next flag value.

    // A set in the clear cycle wins so no event is lost.
    always_comb begin
        if (set) begin
            q_next = 1'b1;
        end else if (clr) begin
            q_next = 1'b0;
        end else begin
            q_next = q_reg;
        end
    end

    // Register the flag; it resets clear.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_reg <= 1'b0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q = q_reg;

endmodule : pss_flag_hi

// ---- pss_flag_lo.sv ----
// Latched-low flag: holds a loss until read, then reloads the live level.
`timescale 1ns/1ps

module pss_flag_lo (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // Live condition and read strobe.
    input wire logic live,
    input wire logic rd,
    // Flag value.
    output logic q
);

    logic q_reg;   // Flag storage.
    logic q_next;  // Next flag value.

    // A read reloads the live level; otherwise any drop sticks at zero.
    always_comb begin
        if (rd) begin
            q_next = live;
        end else begin
            q_next = q_reg & live;
        end
    end

    // Register the flag; it resets to zero.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q_reg <= 1'b0;
        end else begin
            q_reg <= q_next;
        end
    end

    assign q = q_reg;

endmodule : pss_flag_lo

// ---- pss_top.sv ----
// Upper status summary bits with AHB-Lite register access and event interrupt.
//
// The AHB-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps

module pss_top (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // PHY conditions and neighbouring register read strobes.
    input wire pss_pkg::pss_phy_t phy,
    input wire pss_pkg::pss_rdclr_t rdclr,
    // Interrupt.
    output logic irq
);
    import pss_pkg::*;

    // ************************************************************
    // Bus address phase capture
    // ************************************************************
    logic accept;                // Valid transfer taken this cycle.
    logic rd_accept;             // Read taken this cycle.
    logic [7:0] a_off;           // Word offset inside the block.
    logic wr_pend_reg;           // A write data phase is due.
    logic wr_pend_next;          // Next write pending flag.
    logic [7:0] wr_off_reg;      // Offset of the pending write.
    logic [7:0] wr_off_next;     // Next pending write offset.
    logic [31:0] hrdata_reg;     // Registered read data.
    logic [31:0] hrdata_next;    // Read data for the next data phase.
    logic hreadyout_reg;         // Always ready: zero wait states.
    logic hresp_reg;             // Always OKAY.

    // Only the low byte of the address decodes; upper bits alias.
    assign a_off = {haddr[7:2], 2'b00};
    assign accept = hsel & hready & htrans[1];
    assign rd_accept = accept & ~hwrite;

    // ************************************************************
    // Control and interrupt registers
    // ************************************************************
    logic [PSS_CTRL_W-1:0] ctrl_reg;   // Crossover and detect control.
    logic [PSS_CTRL_W-1:0] ctrl_next;  // Next control value.
    logic [PSS_NEV-1:0] ist_reg;       // Sticky event status.
    logic [PSS_NEV-1:0] ist_next;      // Next event status.
    logic [PSS_NEV-1:0] ien_reg;       // Event enables.
    logic [PSS_NEV-1:0] ien_next;      // Next enables.
    logic irq_reg;                     // Interrupt output flop.
    logic irq_next;                    // Next interrupt level.
    logic [PSS_NEV-1:0] ev;            // Event pulses this cycle.
    logic [PSS_NEV-1:0] wclr;          // Bits software clears this cycle.

    // ************************************************************
    // Status summary sources
    // ************************************************************
    logic xover_reg;        // Crossover state flop.
    logic xover_next;       // Next crossover state.
    logic rxerr_q;          // Receive error latch.
    logic fcs_q;            // False carrier latch.
    logic pol_q;            // Polarity copy.
    logic page_q;           // Page received copy.
    logic int_q;            // Interrupt pending.
    logic sd_q;             // Latched-low signal detect.
    logic lock_q;           // Latched-low descrambler lock.
    logic sd_live;          // Selected live signal detect.
    logic sum_rd;           // Read of the summary register.
    logic [15:0] summary;   // Assembled summary word.
    logic [5:0] prev_reg;   // Previous latch values for edge events.
    logic [5:0] prev_next;  // Next previous values.

    // ************************************************************
    // Crossover state
    // ************************************************************
    // Force pins the crossed state; enable alone follows the algorithm.
    always_comb begin
        if (ctrl_reg[PSS_C_XFORCE]) begin
            xover_next = 1'b1;
        end else if (ctrl_reg[PSS_C_XEN]) begin
            xover_next = phy.xover_live;
        end else begin
            xover_next = 1'b0;
        end
    end

    // Register the crossover state so it reads glitch free.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            xover_reg <= 1'b0;
        end else begin
            xover_reg <= xover_next;
        end
    end

    // ************************************************************
    // Latched flags
    // ************************************************************
    // Receive error latch clears only on the counter read.
    pss_flag_hi u_rxerr (
        .hclk(hclk),
        .hresetn(hresetn),
        .set(phy.rx_error),
        .clr(rdclr.rd_rx_err_count),
        .q(rxerr_q)
    );

    // False carrier latch clears only on its counter read.
    pss_flag_hi u_fcs (
        .hclk(hclk),
        .hresetn(hresetn),
        .set(phy.false_carrier),
        .clr(rdclr.rd_fc_count),
        .q(fcs_q)
    );

    // Polarity copy: one while inverted, cleared by the 10BASE-T read.
    pss_flag_hi u_pol (
        .hclk(hclk),
        .hresetn(hresetn),
        .set(phy.polarity_inv),
        .clr(rdclr.rd_tenbase),
        .q(pol_q)
    );

    // Page received copy cleared by the expansion register read.
    pss_flag_hi u_page (
        .hclk(hclk),
        .hresetn(hresetn),
        .set(phy.page_rcvd),
        .clr(rdclr.rd_an_exp),
        .q(page_q)
    );

    // Pending interrupt cleared when software reads the interrupt status.
    pss_flag_hi u_int (
        .hclk(hclk),
        .hresetn(hresetn),
        .set(phy.int_evt),
        .clr(rdclr.rd_int_status),
        .q(int_q)
    );

    // Qualified detect needs both the raw detect and descrambler lock.
    assign sd_live = ctrl_reg[PSS_C_SDQUAL] ? (phy.raw_sd & phy.descr_lock) : phy.raw_sd;
    assign sum_rd = rd_accept & (a_off == PSS_OFF_SUMMARY);

    // Latched-low detect; a summary read reloads the live level.
    pss_flag_lo u_sd (
        .hclk(hclk),
        .hresetn(hresetn),
        .live(sd_live),
        .rd(sum_rd),
        .q(sd_q)
    );

    // Latched-low descrambler lock, reloaded on the same read.
    pss_flag_lo u_lock (
        .hclk(hclk),
        .hresetn(hresetn),
        .live(phy.descr_lock),
        .rd(sum_rd),
        .q(lock_q)
    );

    // Assemble the summary; bit 15 and the low bits are held at zero.
    always_comb begin
        summary = PSS_SUMMARY_RST;
        summary[PSS_B_RSVD] = 1'b0;
        summary[PSS_B_XOVER] = xover_reg;
        summary[PSS_B_RXERR] = rxerr_q;
        summary[PSS_B_POL] = pol_q;
        summary[PSS_B_FCS] = fcs_q;
        summary[PSS_B_SD] = sd_q;
        summary[PSS_B_LOCK] = lock_q;
        summary[PSS_B_PAGE] = page_q;
        summary[PSS_B_INT] = int_q;
    end

    // ************************************************************
    // Event detection
    // ************************************************************
    // Rising edges of latched-high flags other than polarity and falling edges of latched-low ones.
    always_comb begin
        prev_next = {lock_q, sd_q, int_q, page_q, fcs_q, rxerr_q};
        ev = '0;
        ev[PSS_E_RXERR] = rxerr_q & ~prev_reg[0];
        ev[PSS_E_FCS] = fcs_q & ~prev_reg[1];
        ev[PSS_E_PAGE] = page_q & ~prev_reg[2];
        ev[PSS_E_INT] = int_q & ~prev_reg[3];
        ev[PSS_E_SDLOSS] = ~sd_q & prev_reg[4];
        ev[PSS_E_LOCKLOSS] = ~lock_q & prev_reg[5];
    end

    // Remember the flags one cycle back.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prev_reg <= 6'h00;
        end else begin
            prev_reg <= prev_next;
        end
    end

    // ************************************************************
    // Register writes and interrupt status
    // ************************************************************
    // Writes land in the data phase; writes to the summary are dropped.
    always_comb begin
        ctrl_next = ctrl_reg;
        ien_next = ien_reg;
        wclr = '0;
        if (wr_pend_reg) begin
            case (wr_off_reg)
                PSS_OFF_CTRL: begin
                    ctrl_next = hwdata[PSS_CTRL_W-1:0];
                end
                PSS_OFF_IRQ_EN: begin
                    ien_next = hwdata[PSS_NEV-1:0];
                end
                PSS_OFF_IRQ_CLR: begin
                    wclr = hwdata[PSS_NEV-1:0];
                end
                default: begin
                    ctrl_next = ctrl_reg;
                end
            endcase
        end
        // A new event beats a clear in the same cycle.
        ist_next = (ist_reg & ~wclr) | ev;
        irq_next = |(ist_next & ien_next);
    end

    // Register control, status, enables and the interrupt line.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= PSS_CTRL_RST;
            ist_reg <= PSS_IRQ_RST;
            ien_reg <= PSS_IRQ_RST;
            irq_reg <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            ist_reg <= ist_next;
            ien_reg <= ien_next;
            irq_reg <= irq_next;
        end
    end

    // ************************************************************
    // Bus read path
    // ************************************************************
    // Read data is sampled at the address phase so the value before any
    // read side effect is returned; unmapped offsets read zero.
    always_comb begin
        wr_pend_next = accept & hwrite;
        wr_off_next = accept ? a_off : wr_off_reg;
        hrdata_next = hrdata_reg;
        if (rd_accept) begin
            case (a_off)
                PSS_OFF_SUMMARY: begin
                    hrdata_next = {16'h0000, summary};
                end
                PSS_OFF_CTRL: begin
                    hrdata_next = {29'h0000000, ctrl_reg};
                end
                PSS_OFF_IRQ_STAT: begin
                    hrdata_next = {26'h0000000, ist_reg};
                end
                PSS_OFF_IRQ_EN: begin
                    hrdata_next = {26'h0000000, ien_reg};
                end
                default: begin
                    hrdata_next = 32'h00000000;
                end
            endcase
        end
    end

    // Register the bus state; the slave never inserts waits or errors.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
            wr_off_reg <= 8'h00;
            hrdata_reg <= 32'h00000000;
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_off_reg <= wr_off_next;
            hrdata_reg <= hrdata_next;
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp = hresp_reg;
    assign irq = irq_reg;

endmodule : pss_top

// ---- pss_top_props.sv ----
// Concurrent property checker for the status summary block, bound to its top module.
`timescale 1ns/1ps

module pss_top_props (
    // Clock and reset.
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave side.
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // PHY conditions and clear strobes.
    input wire pss_pkg::pss_phy_t phy,
    input wire pss_pkg::pss_rdclr_t rdclr
);
    import pss_pkg::*;

    // ************************************************************
    // Helpers
    // ************************************************************
    // A summary read is taken at this edge; its data stand right after it.
    logic sum_rd;
    // Both link conditions healthy, so latched-low bits may recover.
    logic link_ok;
    assign sum_rd = hsel && hready && htrans[1] && !hwrite && (haddr[7:2] == 6'h00);
    assign link_ok = phy.raw_sd && phy.descr_lock;

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // A cause at one edge, then a summary read taken at the next edge.
    sequence s_then_read(c);
        c ##1 sum_rd;
    endsequence

    // ************************************************************
    // Properties
    // ************************************************************
    // Everything outside bits 14 to 7 must read zero.
    rsvd_zero_a: assert property (sum_rd |=> hrdata[31:15] == 17'h0 && hrdata[6:0] == 7'h00)
        else $error("summary reserved bits not zero");
    rxerr_set_a: assert property (s_then_read(phy.rx_error) |=> hrdata[13])
        else $error("receive error latch not set");
    // The clear is checked only when no new event competes at the same edge.
    rxerr_clear_a: assert property (s_then_read(rdclr.rd_rx_err_count && !phy.rx_error)
        |=> !hrdata[13])
        else $error("receive error latch not cleared");
    fcs_set_a: assert property (s_then_read(phy.false_carrier) |=> hrdata[11])
        else $error("false carrier latch not set");
    pol_set_a: assert property (s_then_read(phy.polarity_inv) |=> hrdata[12])
        else $error("polarity bit not set");
    pol_clear_a: assert property (s_then_read(rdclr.rd_tenbase && !phy.polarity_inv)
        |=> !hrdata[12])
        else $error("polarity bit not cleared");
    page_set_a: assert property (s_then_read(phy.page_rcvd) |=> hrdata[8])
        else $error("page received bit not set");
    int_set_a: assert property (s_then_read(phy.int_evt) |=> hrdata[7])
        else $error("interrupt pending bit not set");
    int_clear_a: assert property (s_then_read(rdclr.rd_int_status && !phy.int_evt)
        |=> !hrdata[7])
        else $error("interrupt pending bit not cleared");
    sd_loss_a: assert property (s_then_read(!phy.raw_sd) |=> !hrdata[10])
        else $error("signal detect loss not held");
    lock_loss_a: assert property (s_then_read(!phy.descr_lock) |=> !hrdata[9])
        else $error("descrambler lock loss not held");
    // After a reloading read with a healthy link, both bits must come back up.
    ll_recover_a: assert property (sum_rd && link_ok ##1 link_ok ##1 sum_rd
        |=> hrdata[10] && hrdata[9])
        else $error("latched-low bits did not recover");

endmodule : pss_top_props

bind pss_top pss_top_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .phy(phy), .rdclr(rdclr));

// ---- pss_top_tb.sv ----
// Self-checking bench for the status summary block over AHB-Lite.
`timescale 1ns/1ps

module pss_top_tb;
    import pss_pkg::*;

    // ************************************************************
    // Stimulus, results and tables
    // ************************************************************
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq; // Bus control and outputs.
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd; // The rd variable holds the last read word.
    pss_phy_t phy;
    pss_rdclr_t rdclr;
    int fails, n_checks, cycles;
    // Event masks, their clear strobes and the summary bit each one lands in.
    pss_phy_t ev_m[5] = '{8'h40, 8'h20, 8'h02, 8'h01, 8'h10};
    pss_rdclr_t cl_m[5] = '{5'h10, 5'h08, 5'h02, 5'h01, 5'h04};
    int ev_b[5] = '{13, 11, 8, 7, 12};
    logic [7:0] offs[6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h20};

    // The slave is the only one, so its ready is the bus ready; size is always a word.
    pss_top DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .phy(phy), .rdclr(rdclr), .irq(irq));

    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    // Cut a hang short; the whole run needs well under a thousand cycles.
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fails++;
            end_of_test();
        end
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One single transfer; data are taken at the edge that ends the data phase.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask : xfer

    task automatic bwrite(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : bwrite

    task automatic bread(input logic [7:0] a);
        xfer(1'b0, a, 32'h0);
    endtask : bread

    // One-cycle event and clear strobes, lined up with a clock edge.
    task automatic pulse(input pss_phy_t p, input pss_rdclr_t r);
        phy <= phy | p;
        rdclr <= r;
        @(posedge hclk);
        phy <= phy & ~p;
        rdclr <= 5'h00;
    endtask : pulse

    // The interrupt line is sampled mid-cycle, away from the launching edge.
    task automatic irq_is(input logic exp);
        @(negedge hclk);
        chk("irq", {31'h0, exp}, {31'h0, irq});
        @(posedge hclk);
    endtask : irq_is

    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        phy = '0;
        rdclr = '0;
        {fails, n_checks, cycles} = '0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Reset values of every register and of an unmapped place.
        foreach (offs[i]) begin
            bread(offs[i]);
            chk("reset value", 32'h0, rd);
            // The slave never stalls and always answers OKAY.
            chk("ready and okay", 32'h2, {30'h0, hreadyout, hresp});
        end
        bwrite(PSS_OFF_SUMMARY, 32'hffff_ffff);
        bread(PSS_OFF_SUMMARY);
        chk("summary after write", 32'h0, rd);
        // Every mix of enable, force and live crossover state.
        for (int i = 0; i < 8; i++) begin
            bwrite(PSS_OFF_CTRL, {30'h0, i[1:0]});
            phy.xover_live <= i[2];
            repeat (2) @(posedge hclk);
            bread(PSS_OFF_SUMMARY);
            chk("crossover", {31'h0, i[1] | (i[0] & i[2])}, {31'h0, rd[14]});
        end
        // Each latch sets, survives a foreign clear and a summary read, then clears.
        for (int i = 0; i < 5; i++) begin
            pulse(ev_m[i], 5'h00);
            bread(PSS_OFF_SUMMARY);
            chk("latch set", 32'h1, {31'h0, rd[ev_b[i]]});
            pulse(8'h00, cl_m[(i + 1) % 5]);
            bread(PSS_OFF_SUMMARY);
            chk("latch hold", 32'h1, {31'h0, rd[ev_b[i]]});
            pulse(8'h00, cl_m[i]);
            bread(PSS_OFF_SUMMARY);
            chk("latch clear", 32'h0, {31'h0, rd[ev_b[i]]});
        end
        // Latched-low bits with the signal detect qualified, then raw.
        phy.raw_sd <= 1'b1;
        phy.descr_lock <= 1'b1;
        bread(PSS_OFF_SUMMARY);
        bread(PSS_OFF_SUMMARY);
        chk("link up", 32'h3, {30'h0, rd[10:9]});
        for (int i = 0; i < 2; i++) begin
            bwrite(PSS_OFF_CTRL, {29'h0, ~i[0], 2'h0});
            phy.descr_lock <= 1'b0;
            @(posedge hclk);
            phy.descr_lock <= 1'b1;
            bread(PSS_OFF_SUMMARY);
            chk("lock loss", {30'h0, i[0], 1'b0}, {30'h0, rd[10:9]});
            bread(PSS_OFF_SUMMARY);
            chk("reload", 32'h3, {30'h0, rd[10:9]});
        end
        // Interrupt: raise, mask, unmask, clear; status stays read-only.
        bwrite(PSS_OFF_IRQ_CLR, 32'h3f);
        bread(PSS_OFF_IRQ_STAT);
        chk("status cleared", 32'h0, rd);
        bwrite(PSS_OFF_IRQ_EN, 32'h3f);
        pulse(8'h40, 5'h00);
        repeat (3) @(posedge hclk);
        irq_is(1'b1);
        bread(PSS_OFF_IRQ_STAT);
        chk("status event", 32'h1, rd);
        bwrite(PSS_OFF_IRQ_STAT, 32'h3f);
        bread(PSS_OFF_IRQ_STAT);
        chk("status read only", 32'h1, rd);
        bwrite(PSS_OFF_IRQ_EN, 32'h3e);
        irq_is(1'b0);
        bwrite(PSS_OFF_IRQ_EN, 32'h3f);
        irq_is(1'b1);
        bwrite(PSS_OFF_IRQ_CLR, 32'h1);
        irq_is(1'b0);
        bread(PSS_OFF_IRQ_CLR);
        chk("clear reads zero", 32'h0, rd);
        bread(PSS_OFF_IRQ_EN);
        chk("enable", 32'h3f, rd);
        end_of_test();
    end

endmodule : pss_top_tb
